// >>> rtl/tsr_consts.vh
// Register map, field positions and reset values of the split timer and timer 2 block.
// Assumes a classic Wishbone slave with 32-bit data; byte address is four times the index.
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH

// Register indices (word address = byte address bits [9:2]).
`define TSR_IDX_T2_CTRL      8'hC8
`define TSR_IDX_T2_RCAP_LO   8'hCA
`define TSR_IDX_T2_RCAP_HI   8'hCB
`define TSR_IDX_T2_CNT_LO    8'hCC
`define TSR_IDX_T2_CNT_HI    8'hCD
`define TSR_IDX_T01_CTRL     8'h40
`define TSR_IDX_T0_CNT_LO    8'h41
`define TSR_IDX_T0_CNT_HI    8'h42
`define TSR_IDX_T1_CNT_LO    8'h43
`define TSR_IDX_T1_CNT_HI    8'h44
`define TSR_IDX_IRQ_STATUS   8'h48
`define TSR_IDX_IRQ_CLEAR    8'h49
`define TSR_IDX_IRQ_ENABLE   8'h4A

// Timer 2 control fields.
`define TSR_T2_CAP_SEL       0
`define TSR_T2_RUN           2
`define TSR_T2_EXT_EN        3
`define TSR_T2_TX_CLK_SEL    4
`define TSR_T2_RX_CLK_SEL    5
`define TSR_T2_EXT_FLAG      6
`define TSR_T2_OVF_FLAG      7

// Timer 0 and timer 1 control fields.
`define TSR_T01_T0_RUN       0
`define TSR_T01_T1_RUN       1
`define TSR_T01_T0_OVF       2
`define TSR_T01_T1_OVF       3
`define TSR_T01_T0_GATE      4
`define TSR_T01_T0_CNT_SEL   5
`define TSR_T01_T0_SPLIT     6
`define TSR_T01_T1_SPLIT     7

// Interrupt status, clear and enable fields.
`define TSR_IRQ_T0_OVF       0
`define TSR_IRQ_T1_OVF       1
`define TSR_IRQ_T2_OVF       2
`define TSR_IRQ_T2_EXT       3
`define TSR_IRQ_W            4

// Reset values and constants.
`define TSR_BYTE_ZERO        8'h00
`define TSR_BYTE_ONES        8'hFF
`define TSR_WORD_ZERO        16'h0000
`define TSR_WORD_ONES        16'hFFFF
`define TSR_WORD_ONE         16'h0001
`define TSR_BYTE_ONE         8'h01
`define TSR_IRQ_ZERO         4'h0
`define TSR_DAT_ZERO         32'h00000000
`define TSR_PAD_ZERO         24'h000000

`endif

// >>> rtl/tsr_sync3.v
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin is asynchronous to clock; output changes only when stages two and three agree.
`timescale 1ns/1ps
module tsr_sync3 (
  // Clock and reset
  input  wire clock,
  input  wire reset,
  // Pin and result
  input  wire pin,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clock) begin
    if (reset) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Stage one is never looked at here; it only feeds stage two.
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule

// >>> rtl/tsr_top.v
// Timer 0 split mode, timer 1 and timer 2 (autoreload, capture, baud rate) with Wishbone access.
// Assumes one 200 MHz clock that is the machine cycle, and asynchronous external pins.
// Operation
// - Timer 1 in its own split mode stops and holds, as if its run bit were clear.
// - Split timer 0 low byte is an 8-bit counter with timer 0 controls and pin.
// - Split timer 0 high byte counts cycles, uses timer 1 run bit and flag.
// - Timer 1 starts/stops via own split mode, stays a baud source without interrupts.
// - Timer 2 off, autoreload, capture or baud mode from run, clock selects, capture select.
// - Autoreload rollover sets overflow flag and reloads count from reload registers.
// - Autoreload with external enable: falling external edge reloads and sets external flag.
// - Timer 2 control holds external enable bit 3, external flag 6, overflow 7.
// - Capture mode counts 16 bits and sets overflow flag, which can interrupt.
// - Capture with external enable: falling edge copies count to capture registers, sets flag.
// - Timer 2 external flag can interrupt just like the overflow flag.
// - Baud-rate mode never sets the timer 2 overflow flag.
// - Baud-rate mode still lets the external flag raise interrupts.
// - Timer 2 count at 0xCC/0xCD, reload/capture at 0xCA/0xCB.
// - Timer 0 counts only if run set and gate clear or interrupt-0 pin high.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "tsr_consts.vh"
module tsr_top (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // External pins
  input  wire        ext_interrupt_zero_pin,
  input  wire        t0_count_pin,
  input  wire        timer2_external_input,
  // Interrupt and baud ticks
  output reg         irq_q,
  output reg         t1_baud_tick_q,
  output reg         t2_baud_tick_q
);
  // Synchronised pins.
  wire ext_interrupt_zero_pin_s;
  wire t0_pin_s;
  wire timer2_external_input_s;
  reg  t0_pin_prev_q;
  reg  timer2_external_input_prev_q;

  tsr_sync3 u_sync_ext_interrupt_zero_pin (
    .clock   (clock),
    .reset   (reset),
    .pin     (ext_interrupt_zero_pin),
    .level_q (ext_interrupt_zero_pin_s)
  );
  tsr_sync3 u_sync_t0pin (
    .clock   (clock),
    .reset   (reset),
    .pin     (t0_count_pin),
    .level_q (t0_pin_s)
  );
  tsr_sync3 u_sync_timer2_external_input (
    .clock   (clock),
    .reset   (reset),
    .pin     (timer2_external_input),
    .level_q (timer2_external_input_s)
  );

  wire t0_pin_fall = t0_pin_prev_q & ~t0_pin_s;
  wire timer2_external_input_fall   = timer2_external_input_prev_q & ~timer2_external_input_s;

  // Registers.
  reg [7:0] t2_ctrl_q;
  reg [7:0] t2_rcap_lo_q;
  reg [7:0] t2_rcap_hi_q;
  reg [7:0] t2_cnt_lo_q;
  reg [7:0] t2_cnt_hi_q;
  reg [7:0] t01_ctrl_q;
  reg [7:0] t0_cnt_lo_q;
  reg [7:0] t0_cnt_hi_q;
  reg [7:0] t1_cnt_lo_q;
  reg [7:0] t1_cnt_hi_q;
  reg [3:0] irq_status_q;
  reg [3:0] irq_enable_q;

  // Bus decode; the write lands on the edge that raises ack.
  wire       req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr   = req & wb_we_i & wb_sel_i[0];
  wire [7:0] idx  = wb_adr_i[9:2];
  wire [7:0] wdat = wb_dat_i[7:0];

  wire wr_t2_ctrl  = wr & (idx == `TSR_IDX_T2_CTRL);
  wire wr_rcap_lo  = wr & (idx == `TSR_IDX_T2_RCAP_LO);
  wire wr_rcap_hi  = wr & (idx == `TSR_IDX_T2_RCAP_HI);
  wire wr_t2_lo    = wr & (idx == `TSR_IDX_T2_CNT_LO);
  wire wr_t2_hi    = wr & (idx == `TSR_IDX_T2_CNT_HI);
  wire wr_t01_ctrl = wr & (idx == `TSR_IDX_T01_CTRL);
  wire wr_t0_lo    = wr & (idx == `TSR_IDX_T0_CNT_LO);
  wire wr_t0_hi    = wr & (idx == `TSR_IDX_T0_CNT_HI);
  wire wr_t1_lo    = wr & (idx == `TSR_IDX_T1_CNT_LO);
  wire wr_t1_hi    = wr & (idx == `TSR_IDX_T1_CNT_HI);
  wire wr_irq_clr  = wr & (idx == `TSR_IDX_IRQ_CLEAR);
  wire wr_irq_en   = wr & (idx == `TSR_IDX_IRQ_ENABLE);

  // Timer 0 and timer 1 controls.
  wire t0_run   = t01_ctrl_q[`TSR_T01_T0_RUN];
  wire t1_run   = t01_ctrl_q[`TSR_T01_T1_RUN];
  wire t0_gate  = t01_ctrl_q[`TSR_T01_T0_GATE];
  wire t0_csel  = t01_ctrl_q[`TSR_T01_T0_CNT_SEL];
  wire t0_split = t01_ctrl_q[`TSR_T01_T0_SPLIT];
  wire t1_split = t01_ctrl_q[`TSR_T01_T1_SPLIT];

  wire t0_enable = t0_run & (~t0_gate | ext_interrupt_zero_pin_s);
  wire t0_tick   = t0_enable & (t0_csel ? t0_pin_fall : 1'b1);

  wire [15:0] t0_word = {t0_cnt_hi_q, t0_cnt_lo_q};
  wire        t0_lo_inc = t0_tick;
  wire        t0_hi_inc = t0_split ? t1_run : t0_tick & (t0_cnt_lo_q == `TSR_BYTE_ONES);
  wire        t0_ovf_ev = t0_split ? (t0_tick & (t0_cnt_lo_q == `TSR_BYTE_ONES)) :
                                     (t0_tick & (t0_word == `TSR_WORD_ONES));
  wire        th0_ovf   = t0_split & t1_run & (t0_cnt_hi_q == `TSR_BYTE_ONES);

  // Timer 1: under split timer 0 its run bit belongs to the high byte of timer 0.
  wire        t1_count  = t0_split ? ~t1_split : (t1_run & ~t1_split);
  wire [15:0] t1_word   = {t1_cnt_hi_q, t1_cnt_lo_q};
  wire        t1_roll   = t1_count & (t1_word == `TSR_WORD_ONES);
  // Timer 1 rollover only feeds its flag when timer 0 is not holding it.
  wire        t1_ovf_ev = t0_split ? th0_ovf : t1_roll;

  // Timer 2 mode decode.
  wire t2_run   = t2_ctrl_q[`TSR_T2_RUN];
  wire t2_baud  = t2_ctrl_q[`TSR_T2_TX_CLK_SEL] | t2_ctrl_q[`TSR_T2_RX_CLK_SEL];
  wire t2_cap   = t2_ctrl_q[`TSR_T2_CAP_SEL];
  wire t2_exen  = t2_ctrl_q[`TSR_T2_EXT_EN];
  wire m_reload = t2_run & ~t2_baud & ~t2_cap;
  wire m_capt   = t2_run & ~t2_baud & t2_cap;
  wire m_baud   = t2_run & t2_baud;

  wire [15:0] t2_word  = {t2_cnt_hi_q, t2_cnt_lo_q};
  wire [15:0] t2_rcap  = {t2_rcap_hi_q, t2_rcap_lo_q};
  wire        t2_roll  = t2_run & (t2_word == `TSR_WORD_ONES);
  wire        t2_ext   = t2_exen & timer2_external_input_fall & t2_run;
  wire        t2_ovf_ev = t2_roll & ~m_baud;
  wire        t2_ext_ev = t2_ext;
  wire        t2_reload = (t2_roll & (m_reload | m_baud)) | (t2_ext & m_reload);
  wire        t2_grab   = t2_ext & m_capt;

  reg [15:0] t2_next;
  always @* begin
    if (t2_reload) begin
      t2_next = t2_rcap;
    end else if (t2_run) begin
      t2_next = t2_word + `TSR_WORD_ONE;
    end else begin
      t2_next = t2_word;
    end
  end

  reg [15:0] t0_next;
  always @* begin
    t0_next = t0_word;
    if (t0_lo_inc) begin
      t0_next[7:0] = t0_cnt_lo_q + `TSR_BYTE_ONE;
    end
    if (t0_hi_inc) begin
      t0_next[15:8] = t0_cnt_hi_q + `TSR_BYTE_ONE;
    end
  end

  wire [15:0] t1_next = t1_count ? t1_word + `TSR_WORD_ONE : t1_word;

  // Counters; a software write to a byte takes that byte in the same cycle.
  always @(posedge clock) begin
    if (reset) begin
      t0_cnt_lo_q <= `TSR_BYTE_ZERO;
      t0_cnt_hi_q <= `TSR_BYTE_ZERO;
      t1_cnt_lo_q <= `TSR_BYTE_ZERO;
      t1_cnt_hi_q <= `TSR_BYTE_ZERO;
      t2_cnt_lo_q <= `TSR_BYTE_ZERO;
      t2_cnt_hi_q <= `TSR_BYTE_ZERO;
    end else begin
      t0_cnt_lo_q <= wr_t0_lo ? wdat : t0_next[7:0];
      t0_cnt_hi_q <= wr_t0_hi ? wdat : t0_next[15:8];
      t1_cnt_lo_q <= wr_t1_lo ? wdat : t1_next[7:0];
      t1_cnt_hi_q <= wr_t1_hi ? wdat : t1_next[15:8];
      t2_cnt_lo_q <= wr_t2_lo ? wdat : t2_next[7:0];
      t2_cnt_hi_q <= wr_t2_hi ? wdat : t2_next[15:8];
    end
  end

  // Reload/capture registers; a capture beats a software write in the same cycle.
  always @(posedge clock) begin
    if (reset) begin
      t2_rcap_lo_q <= `TSR_BYTE_ZERO;
      t2_rcap_hi_q <= `TSR_BYTE_ZERO;
    end else if (t2_grab) begin
      t2_rcap_lo_q <= t2_cnt_lo_q;
      t2_rcap_hi_q <= t2_cnt_hi_q;
    end else begin
      if (wr_rcap_lo) begin
        t2_rcap_lo_q <= wdat;
      end
      if (wr_rcap_hi) begin
        t2_rcap_hi_q <= wdat;
      end
    end
  end

  // Control registers; hardware setting a flag wins over software clearing it.
  reg [7:0] t2_ctrl_d;
  reg [7:0] t01_ctrl_d;
  always @* begin
    t2_ctrl_d = wr_t2_ctrl ? wdat : t2_ctrl_q;
    t2_ctrl_d[1] = 1'b0;
    if (t2_ovf_ev) begin
      t2_ctrl_d[`TSR_T2_OVF_FLAG] = 1'b1;
    end
    if (t2_ext_ev) begin
      t2_ctrl_d[`TSR_T2_EXT_FLAG] = 1'b1;
    end
    t01_ctrl_d = wr_t01_ctrl ? wdat : t01_ctrl_q;
    if (t0_ovf_ev) begin
      t01_ctrl_d[`TSR_T01_T0_OVF] = 1'b1;
    end
    if (t1_ovf_ev) begin
      t01_ctrl_d[`TSR_T01_T1_OVF] = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      t2_ctrl_q     <= `TSR_BYTE_ZERO;
      t01_ctrl_q    <= `TSR_BYTE_ZERO;
      t0_pin_prev_q <= 1'b1;
      timer2_external_input_prev_q   <= 1'b1;
    end else begin
      t2_ctrl_q     <= t2_ctrl_d;
      t01_ctrl_q    <= t01_ctrl_d;
      t0_pin_prev_q <= t0_pin_s;
      timer2_external_input_prev_q   <= timer2_external_input_s;
    end
  end

  // Sticky interrupt status; a new event beats a clear written in the same cycle.
  wire [3:0] irq_events = {t2_ext_ev, t2_ovf_ev, t1_ovf_ev, t0_ovf_ev};
  wire [3:0] irq_clr    = wr_irq_clr ? wdat[3:0] : `TSR_IRQ_ZERO;
  wire [3:0] irq_status_d = (irq_status_q & ~irq_clr) | irq_events;

  always @(posedge clock) begin
    if (reset) begin
      irq_status_q <= `TSR_IRQ_ZERO;
      irq_enable_q <= `TSR_IRQ_ZERO;
      irq_q        <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_irq_en) begin
        irq_enable_q <= wdat[3:0];
      end
      irq_q <= |(irq_status_q & irq_enable_q);
    end
  end

  // Baud ticks: one cycle per rollover of the source timer.
  always @(posedge clock) begin
    if (reset) begin
      t1_baud_tick_q <= 1'b0;
      t2_baud_tick_q <= 1'b0;
    end else begin
      t1_baud_tick_q <= t1_roll;
      t2_baud_tick_q <= t2_roll & m_baud;
    end
  end

  // Read mux; unmapped and write-only indices read as zero.
  reg [7:0] rdat;
  always @* begin
    case (idx)
      `TSR_IDX_T2_CTRL:    rdat = t2_ctrl_q;
      `TSR_IDX_T2_RCAP_LO: rdat = t2_rcap_lo_q;
      `TSR_IDX_T2_RCAP_HI: rdat = t2_rcap_hi_q;
      `TSR_IDX_T2_CNT_LO:  rdat = t2_cnt_lo_q;
      `TSR_IDX_T2_CNT_HI:  rdat = t2_cnt_hi_q;
      `TSR_IDX_T01_CTRL:   rdat = t01_ctrl_q;
      `TSR_IDX_T0_CNT_LO:  rdat = t0_cnt_lo_q;
      `TSR_IDX_T0_CNT_HI:  rdat = t0_cnt_hi_q;
      `TSR_IDX_T1_CNT_LO:  rdat = t1_cnt_lo_q;
      `TSR_IDX_T1_CNT_HI:  rdat = t1_cnt_hi_q;
      `TSR_IDX_IRQ_STATUS: rdat = {4'h0, irq_status_q};
      `TSR_IDX_IRQ_ENABLE: rdat = {4'h0, irq_enable_q};
      default:             rdat = `TSR_BYTE_ZERO;
    endcase
  end

  // Single-wait Wishbone answer; every address is acknowledged.
  always @(posedge clock) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `TSR_DAT_ZERO;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        wb_dat_o <= {`TSR_PAD_ZERO, rdat};
      end
    end
  end
endmodule

// >>> testbench/tsr_chk.sv
// Checker for the bus answer, interrupt and baud tick ports of tsr_top.
// Assumes it is bound to tsr_top and that reset is held for several cycles.
`timescale 1ns/1ps
module tsr_chk (
  // Clock and reset
  input wire        clock,
  input wire        reset,
  // Bus and outputs
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        irq_q,
  input wire        t1_baud_tick_q,
  input wire        t2_baud_tick_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_dat_pad; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  // Reload in the bench is never above 0xFFF0, so ticks are at least 16 cycles apart.
  property p_t2_tick; t2_baud_tick_q |=> !t2_baud_tick_q [*8]; endproperty
  property p_t1_tick; t1_baud_tick_q |=> !t1_baud_tick_q [*8]; endproperty
  property p_irq_rst; $fell(reset) |-> !irq_q; endproperty
  property p_quiet; $fell(reset) |-> !wb_ack_o && !t2_baud_tick_q; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_ack_next: assert property (p_ack_next) else $error("request not acked");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_pad: assert property (p_dat_pad) else $error("read data upper bits set");
  a_t2_tick: assert property (p_t2_tick) else $error("timer 2 tick too close");
  a_t1_tick: assert property (p_t1_tick) else $error("timer 1 tick too close");
  a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
  a_quiet: assert property (p_quiet) else $error("activity after reset");
  c_t2_tick: cover property (t2_baud_tick_q);
  c_irq: cover property (irq_q);
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind tsr_top tsr_chk u_tsr_chk (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_q(irq_q), .t1_baud_tick_q(t1_baud_tick_q), .t2_baud_tick_q(t2_baud_tick_q));

// >>> testbench/tsr_pins.sv
// Far-side model of the timer 2 trigger pin: one falling pulse per request.
// Assumes fire is a one-cycle request; the pin idles high like a pulled-up line.
`timescale 1ns/1ps
module tsr_pins (
  // Clock
  input wire clock,
  // Request and pin
  input wire fire,
  output reg pin_q
);
  reg [3:0] low_q;
  initial begin
    pin_q = 1'b1;
    low_q = 4'h0;
  end
  // Held low eight cycles so the synchroniser sees a clean high then low sample.
  always @(posedge clock) begin
    low_q <= fire ? 4'h8 : (low_q != 4'h0 ? low_q - 4'h1 : 4'h0);
    pin_q <= !(fire || low_q > 4'h1);
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for tsr_top: registers, timer 2 modes and split timer 0.
// Assumes the pin model on the trigger input and classic Wishbone access.
`timescale 1ns/1ps
module testbench;
  reg         clock;
  reg         reset;
  reg         wb_cyc_i;
  reg         wb_stb_i;
  reg         wb_we_i;
  reg  [11:0] wb_adr_i;
  reg  [31:0] wb_dat_i;
  reg         ext_pin;
  reg         fire;
  reg  [31:0] rdat;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire        irq_q;
  wire        t2_pin;
  wire        t2_tick;
  integer     failures;
  integer     checked;
  integer     ticks;
  tsr_top u_tsr_top (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_interrupt_zero_pin(ext_pin),
    .t0_count_pin(1'b1), .timer2_external_input(t2_pin), .irq_q(irq_q),
    .t1_baud_tick_q(), .t2_baud_tick_q(t2_tick));
  tsr_pins u_tsr_pins (.clock(clock), .fire(fire), .pin_q(t2_pin));
  task test_done;
    begin
      if (failures == 0 && checked > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] idx, input [7:0] d);
    begin
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {2'h0, idx, 2'h0};
      wb_dat_i <= {24'h000000, d};
      @(posedge clock);
      while (wb_ack_o !== 1'b1) @(posedge clock);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task wr(input [7:0] idx, input [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task rd(input [7:0] idx, input [7:0] exp);
    begin
      bus(1'b0, idx, 8'h00);
      chk(rdat, {24'h000000, exp});
    end
  endtask
  task pulse;
    begin
      @(posedge clock) fire <= 1'b1;
      @(posedge clock) fire <= 1'b0;
      repeat (20) @(posedge clock);
    end
  endtask
  task clr;
    begin
      wr(8'hC8, 8'h00);
      wr(8'h49, 8'h0F);
    end
  endtask
  task load(input [15:0] rc, input [15:0] cnt);
    begin
      wr(8'hCA, rc[7:0]);
      wr(8'hCB, rc[15:8]);
      wr(8'hCC, cnt[7:0]);
      wr(8'hCD, cnt[15:8]);
    end
  endtask
  task s_regs;
    begin
      load(16'hA55A, 16'h3C00);
      rd(8'hCA, 8'h5A);
      rd(8'hCB, 8'hA5);
      rd(8'hCD, 8'h3C);
      wr(8'hC8, 8'h0B);
      rd(8'hC8, 8'h09);
      rd(8'h10, 8'h00);
      clr;
    end
  endtask
  task s_reload;
    begin
      wr(8'h4A, 8'h0F);
      load(16'h1234, 16'hFFF8);
      wr(8'hC8, 8'h04);
      repeat (20) @(posedge clock);
      rd(8'hC8, 8'h84);
      rd(8'hCD, 8'h12);
      chk(irq_q, 1'b1);
      clr;
      rd(8'h48, 8'h00);
      repeat (2) @(posedge clock);
      chk(irq_q, 1'b0);
    end
  endtask
  // Only baud mode starts near rollover; the others start at zero so that no overflow
  // flag can mix into the external-flag checks, and a reload shows up in the count.
  task s_ext(input [7:0] ctl, input [15:0] rc, input [7:0] idx, input [7:0] hi,
             input [7:0] st);
    begin
      load(rc, ctl[4] ? 16'hFFF0 : 16'h0000);
      if (ctl[0]) load(16'h55F0, 16'h0000);
      wr(8'hC8, ctl);
      pulse;
      repeat (20) @(posedge clock);
      rd(idx, hi);
      rd(8'hC8, st);
      rd(8'h48, 8'h08);
      chk(irq_q, 1'b1);
      clr;
    end
  endtask
  task s_split;
    begin
      wr(8'h43, 8'h33);
      wr(8'h42, 8'hF0);
      wr(8'h41, 8'h05);
      wr(8'h40, 8'hD3);
      repeat (40) @(posedge clock);
      rd(8'h43, 8'h33);
      rd(8'h41, 8'h05);
      rd(8'h40, 8'hDB);
      rd(8'h48, 8'h02);
      ext_pin <= 1'b1;
      wr(8'h40, 8'h51);
      repeat (10) @(posedge clock);
      bus(1'b0, 8'h43, 8'h00);
      chk(rdat != 32'h00000033, 1'b1);
      bus(1'b0, 8'h41, 8'h00);
      chk(rdat != 32'h00000005, 1'b1);
    end
  endtask
  always @(posedge clock) if (t2_tick === 1'b1) ticks <= ticks + 1;
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #100000;
    failures = failures + 1;
    test_done;
  end
  initial begin
    {failures, checked, ticks} = {32'h0, 32'h0, 32'h0};
    {reset, wb_cyc_i, wb_stb_i, wb_we_i, ext_pin, fire} = 6'h20;
    {wb_adr_i, wb_dat_i} = 44'h0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    s_regs;
    s_reload;
    s_ext(8'h0D, 16'h0000, 8'hCB, 8'h00, 8'h4D);
    s_ext(8'h0C, 16'hAB00, 8'hCD, 8'hAB, 8'h4C);
    s_ext(8'h1C, 16'hFFF0, 8'hCB, 8'hFF, 8'h5C);
    chk(ticks != 0, 1'b1);
    s_split;
    test_done;
  end
endmodule
